//--- jrx_pkg.sv
// Constants shared by both ends of the receive-side link check block.
// Assumes byte-wide registers on a 32-bit APB word, index times four.
// Functional notes
// - Expected sample high byte, read/write, resets zero
// - Result bit 0: zero pass, one fail
// - Software writes 0x01 to setup byte first
// - Mask bit set inverts that lane's bits
// - Lane 0 device number captured, read-only
// - Bank number captured into low nibble
// - Transmitter announces adjust resolution zero
// - Transmitter announces adjust direction, phase request zero
// - Lane identifier in low five bits; receiver capture masks with LANE_ID_MASK and keeps the low seven
// - Scrambling flag shown in bit 7
// - Lane count minus one, five bits
// - Octets per frame minus one: 0,1,3
// - Expected sample low byte, read/write, resets zero
// - Converter and sample index select checked sample
// - Writing clear bit resets the stored result
// - Comparison runs only while enable is set
package jrx_pkg;
	// ----------------------------------------
	// Register indices (byte address is index times four)
	// ----------------------------------------
	localparam logic [11:0] IDX_CHECK_CTRL = 12'h032C;
	localparam logic [11:0] IDX_EXP_LOW = 12'h032D;
	localparam logic [11:0] IDX_EXP_HIGH = 12'h032E;
	localparam logic [11:0] IDX_CHECK_RESULT = 12'h032F;
	localparam logic [11:0] IDX_LINK_SETUP = 12'h0333;
	localparam logic [11:0] IDX_LANE_POLARITY = 12'h0334;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'h0340;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h0341;
	localparam logic [11:0] IDX_RX_DEVICE = 12'h0400;
	localparam logic [11:0] IDX_RX_BANK = 12'h0401;
	localparam logic [11:0] IDX_RX_LANE_ID = 12'h0402;
	localparam logic [11:0] IDX_RX_SCR_L = 12'h0403;
	localparam logic [11:0] IDX_RX_OCTETS = 12'h0404;
	// ----------------------------------------
	// Field positions and values
	// ----------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam int CTRL_SAMPLE_LSB = 4;
	localparam int CTRL_CONV_LSB = 2;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h3F;
	localparam logic [7:0] LANE_ID_MASK = 8'h7F;
	localparam logic [7:0] SCR_L_MASK = 8'h9F;
	localparam logic [7:0] LINK_SETUP_VALUE = 8'h01;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int IRQ_FAIL_BIT = 0;
	localparam int IRQ_CFG_BIT = 1;
	localparam int IRQ_BITS = 2;
	// ----------------------------------------
	// Link geometry and configuration sequence
	// ----------------------------------------
	localparam int NUM_LANES = 8;
	localparam int LANE_WIDTH = 32;
	localparam int SAMPLE_WIDTH = 16;
	localparam int CFG_OCTETS = 5;
	localparam logic [2:0] CFG_LAST = 3'h4;
	localparam logic [1:0] OCTETS_CODE_FOUR = 2'h3;
endpackage

//--- jrx_link_if.sv
// Link between the transmitter end and the receiver register end.
// Assumes both ends share i_clk_sys; the bench joins the modports.
`timescale 1ns/1ns
interface jrx_link_if;
	import jrx_pkg::*;
	logic [NUM_LANES*LANE_WIDTH-1:0] lane_data;
	logic data_valid;
	logic cfg_start;
	logic cfg_valid;
	modport rx (input lane_data, input data_valid, input cfg_start, input cfg_valid);
	modport tx (output lane_data, output data_valid, output cfg_start, output cfg_valid);
endinterface

//--- jrx_sample_pick.sv
// Selects one received sample and compares it with the reference.
// Assumes the word is already polarity corrected by the caller.
`timescale 1ns/1ns
module jrx_sample_pick #(
	parameter int WORD_W = jrx_pkg::NUM_LANES * jrx_pkg::LANE_WIDTH
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic [WORD_W-1:0] i_word,
	input wire logic i_valid,
	input wire logic i_enable,
	input wire logic i_clear,
	input wire logic [1:0] i_conv,
	input wire logic [1:0] i_smp,
	input wire logic [jrx_pkg::SAMPLE_WIDTH-1:0] i_ref,
	output logic o_fail,
	output logic o_fail_event
);
	import jrx_pkg::*;

	typedef struct packed {
		logic fail;
	} jrx_pick_state_t;

	jrx_pick_state_t state_reg;
	jrx_pick_state_t state_next;
	logic [SAMPLE_WIDTH-1:0] picked;
	logic mismatch;

	always_comb begin
		picked = i_word[{i_conv, i_smp}*SAMPLE_WIDTH +: SAMPLE_WIDTH];
		mismatch = i_enable && i_valid && (picked != i_ref);
		state_next = state_reg;
		// Clear is a level: held high it keeps the result at pass
		if (i_clear) begin
			state_next.fail = 1'b0;
		end else if (mismatch) begin
			state_next.fail = 1'b1;
		end
		o_fail_event = state_next.fail && !state_reg.fail;
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= '0;
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	assign o_fail = state_reg.fail;
endmodule

//--- jrx_rx_regs.sv
// Receiver end: APB register bank, lane polarity, sample check and
// capture of the link parameters announced on lane 0.
// Assumes APB signals synchronous to i_clk_sys; zero wait states while i_clk_en is high.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
module jrx_rx_regs (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	jrx_link_if.rx link,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [13:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	output logic o_link_setup_ok,
	output logic [jrx_pkg::NUM_LANES*jrx_pkg::LANE_WIDTH-1:0] o_rx_word,
	output logic o_rx_valid
);
	import jrx_pkg::*;

	localparam int WORD_W = NUM_LANES * LANE_WIDTH;

	typedef struct packed {
		logic [7:0] check_ctrl;
		logic [7:0] exp_low;
		logic [7:0] exp_high;
		logic [7:0] link_setup;
		logic [7:0] polarity;
		logic [7:0] rx_device;
		logic [7:0] rx_bank;
		logic [7:0] rx_lane_id;
		logic [7:0] rx_scr_l;
		logic [7:0] rx_octets;
		logic [IRQ_BITS-1:0] irq_status;
		logic [IRQ_BITS-1:0] irq_mask;
		logic cfg_busy;
		logic [2:0] cfg_idx;
		logic [31:0] prdata;
		logic [WORD_W-1:0] rx_word;
		logic rx_valid;
	} jrx_rx_state_t;

	jrx_rx_state_t state_reg;
	jrx_rx_state_t state_next;
	logic [WORD_W-1:0] fixed_word;
	logic [7:0] cfg_octet;
	logic [7:0] rd_byte;
	logic [11:0] idx;
	logic wr_go;
	logic access;
	logic check_fail;
	logic fail_event;
	logic cfg_done;
	logic [IRQ_BITS-1:0] w1c;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Inverts every bit of each lane whose mask bit is one
	function automatic logic [WORD_W-1:0] lane_flip(input logic [WORD_W-1:0] data,
		input logic [7:0] mask);
		logic [WORD_W-1:0] res;
		res = data;
		for (int l = 0; l < NUM_LANES; l++) begin
			if (mask[l]) begin
				res[l*LANE_WIDTH +: LANE_WIDTH] = ~data[l*LANE_WIDTH +: LANE_WIDTH];
			end
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		return a inside {IDX_CHECK_CTRL, IDX_EXP_LOW, IDX_EXP_HIGH, IDX_CHECK_RESULT,
			IDX_LINK_SETUP, IDX_LANE_POLARITY, IDX_IRQ_STATUS, IDX_IRQ_MASK,
			IDX_RX_DEVICE, IDX_RX_BANK, IDX_RX_LANE_ID, IDX_RX_SCR_L, IDX_RX_OCTETS};
	endfunction

	// ----------------------------------------
	// Sample check
	// ----------------------------------------
	jrx_sample_pick #(
		.WORD_W(WORD_W)
	) u_pick (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_word(fixed_word),
		.i_valid(link.data_valid),
		.i_enable(state_reg.check_ctrl[CTRL_ENABLE_BIT]),
		.i_clear(state_reg.check_ctrl[CTRL_CLEAR_BIT]),
		.i_conv(state_reg.check_ctrl[CTRL_CONV_LSB +: 2]),
		.i_smp(state_reg.check_ctrl[CTRL_SAMPLE_LSB +: 2]),
		.i_ref({state_reg.exp_high, state_reg.exp_low}),
		.o_fail(check_fail),
		.o_fail_event(fail_event)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		fixed_word = lane_flip(link.lane_data, state_reg.polarity);
		cfg_octet = fixed_word[7:0];
		idx = i_paddr[13:2];
		access = i_psel && i_penable;
		wr_go = access && i_pwrite;
		cfg_done = 1'b0;
		w1c = '0;

		// ----------------------------------------
		// Register read
		// ----------------------------------------
		unique case (idx)
			IDX_CHECK_CTRL: rd_byte = state_reg.check_ctrl;
			IDX_EXP_LOW: rd_byte = state_reg.exp_low;
			IDX_EXP_HIGH: rd_byte = state_reg.exp_high;
			IDX_CHECK_RESULT: rd_byte = {7'h00, check_fail};
			IDX_LINK_SETUP: rd_byte = state_reg.link_setup;
			IDX_LANE_POLARITY: rd_byte = state_reg.polarity;
			IDX_IRQ_STATUS: rd_byte = {6'h00, state_reg.irq_status};
			IDX_IRQ_MASK: rd_byte = {6'h00, state_reg.irq_mask};
			IDX_RX_DEVICE: rd_byte = state_reg.rx_device;
			IDX_RX_BANK: rd_byte = state_reg.rx_bank;
			IDX_RX_LANE_ID: rd_byte = state_reg.rx_lane_id;
			IDX_RX_SCR_L: rd_byte = state_reg.rx_scr_l;
			IDX_RX_OCTETS: rd_byte = state_reg.rx_octets;
			default: rd_byte = RESET_BYTE;
		endcase

		// Latched in every selected cycle, so a stretched access still returns fresh data
		if (i_psel) begin
			state_next.prdata = {24'h00_0000, rd_byte};
		end

		// ----------------------------------------
		// Register write
		// ----------------------------------------
		// Writes to read-only or unmapped words change nothing
		if (wr_go) begin
			unique case (idx)
				IDX_CHECK_CTRL: state_next.check_ctrl = i_pwdata[7:0] & CTRL_WRITE_MASK;
				IDX_EXP_LOW: state_next.exp_low = i_pwdata[7:0];
				IDX_EXP_HIGH: state_next.exp_high = i_pwdata[7:0];
				IDX_LINK_SETUP: state_next.link_setup = i_pwdata[7:0];
				IDX_LANE_POLARITY: state_next.polarity = i_pwdata[7:0];
				IDX_IRQ_STATUS: w1c = i_pwdata[IRQ_BITS-1:0];
				IDX_IRQ_MASK: state_next.irq_mask = i_pwdata[IRQ_BITS-1:0];
				default: ;
			endcase
		end

		// ----------------------------------------
		// Lane 0 configuration capture
		// ----------------------------------------
		// Configuration octets arrive on lane 0 one per cfg_valid cycle
		if (link.cfg_start) begin
			state_next.cfg_busy = 1'b1;
			state_next.cfg_idx = '0;
		end else if (state_reg.cfg_busy && link.cfg_valid) begin
			unique case (state_reg.cfg_idx)
				3'h0: state_next.rx_device = cfg_octet;
				3'h1: state_next.rx_bank = cfg_octet;
				3'h2: state_next.rx_lane_id = cfg_octet & LANE_ID_MASK;
				3'h3: state_next.rx_scr_l = cfg_octet & SCR_L_MASK;
				default: state_next.rx_octets = cfg_octet;
			endcase
			state_next.cfg_idx = state_reg.cfg_idx + 3'h1;
			if (state_reg.cfg_idx == CFG_LAST) begin
				state_next.cfg_busy = 1'b0;
				cfg_done = 1'b1;
			end
		end

		// ----------------------------------------
		// Interrupt status
		// ----------------------------------------
		// A new event wins over a clear in the same cycle
		state_next.irq_status = (state_reg.irq_status & ~w1c)
			| {cfg_done, fail_event};

		state_next.rx_word = fixed_word;
		state_next.rx_valid = link.data_valid;
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= '0;
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_prdata = state_reg.prdata;
	// Stalls while the clock enable is low, so a frozen bank never drops a write
	assign o_pready = access && i_clk_en;
	assign o_pslverr = access && !is_mapped(idx);
	assign o_irq = |(state_reg.irq_status & state_reg.irq_mask);
	// Capture does not wait for this; it only reports the setup byte
	assign o_link_setup_ok = (state_reg.link_setup == LINK_SETUP_VALUE);
	assign o_rx_word = state_reg.rx_word;
	assign o_rx_valid = state_reg.rx_valid;
endmodule

//--- jrx_tx_end.sv
// Transmitter end: sends the lane 0 configuration sequence and then
// sample words over the link. Assumes a user that pulses i_cfg_send.
`timescale 1ns/1ns
module jrx_tx_end (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	jrx_link_if.tx link,
	input wire logic i_cfg_send,
	input wire logic [7:0] i_device_number,
	input wire logic [3:0] i_bank_number,
	input wire logic [4:0] i_lane_identifier,
	input wire logic i_scramble,
	input wire logic [4:0] i_lane_count_code,
	input wire logic [1:0] i_octets_sel,
	input wire logic [jrx_pkg::NUM_LANES*jrx_pkg::LANE_WIDTH-1:0] i_sample_word,
	input wire logic i_sample_valid,
	output logic o_cfg_busy
);
	import jrx_pkg::*;

	localparam int WORD_W = NUM_LANES * LANE_WIDTH;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_SEND
	} jrx_tx_mode_t;

	typedef struct packed {
		jrx_tx_mode_t mode;
		logic [2:0] idx;
		logic [WORD_W-1:0] lane_data;
		logic data_valid;
		logic cfg_start;
		logic cfg_valid;
	} jrx_tx_state_t;

	jrx_tx_state_t state_reg;
	jrx_tx_state_t state_next;
	logic [7:0] octet;

	// Only one, two or four octets per frame may be announced
	function automatic logic [7:0] octets_code(input logic [1:0] sel);
		return (sel[1]) ? {6'h00, OCTETS_CODE_FOUR} : {7'h00, sel[0]};
	endfunction

	always_comb begin
		state_next = state_reg;
		state_next.cfg_start = 1'b0;
		state_next.cfg_valid = 1'b0;
		state_next.data_valid = 1'b0;
		unique case (state_reg.idx)
			3'h0: octet = i_device_number;
			3'h1: octet = {4'h0, i_bank_number};
			3'h2: octet = {3'h0, i_lane_identifier};
			3'h3: octet = {i_scramble, 2'h0, i_lane_count_code};
			default: octet = octets_code(i_octets_sel);
		endcase
		unique case (state_reg.mode)
			ST_IDLE: begin
				if (i_cfg_send) begin
					state_next.mode = ST_START;
					state_next.cfg_start = 1'b1;
					state_next.idx = '0;
				end else begin
					state_next.lane_data = i_sample_word;
					state_next.data_valid = i_sample_valid;
				end
			end
			ST_START, ST_SEND: begin
				state_next.mode = ST_SEND;
				state_next.lane_data = {{(WORD_W-8){1'b0}}, octet};
				state_next.cfg_valid = 1'b1;
				state_next.idx = state_reg.idx + 3'h1;
				if (state_reg.idx == CFG_LAST) begin
					state_next.mode = ST_IDLE;
				end
			end
			default: state_next.mode = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= '{mode: ST_IDLE, default: '0};
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	assign link.lane_data = state_reg.lane_data;
	assign link.data_valid = state_reg.data_valid;
	assign link.cfg_start = state_reg.cfg_start;
	assign link.cfg_valid = state_reg.cfg_valid;
	assign o_cfg_busy = (state_reg.mode != ST_IDLE);
endmodule

//--- jrx_checker.sv
// Assertions on the link wires between the two ends.
// Assumes the bench hands it the link interface signals by name.
`timescale 1ns/1ns
module jrx_checker (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic [jrx_pkg::NUM_LANES*jrx_pkg::LANE_WIDTH-1:0] i_lane_data,
	input wire logic i_data_valid,
	input wire logic i_cfg_start,
	input wire logic i_cfg_valid
);
	import jrx_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// ----------------------------------------
	// Configuration framing on lane 0
	// ----------------------------------------
	a_cfg_frame_len: assert property (i_cfg_start |=> i_cfg_valid [*5])
		else $error("config frame shorter than five octets");
	a_cfg_frame_end: assert property (i_cfg_start ##1 !i_cfg_start [*5] |=> !i_cfg_valid)
		else $error("config frame longer than five octets");
	a_cfg_no_stray: assert property ($rose(i_cfg_valid) |-> $past(i_cfg_start))
		else $error("config octet without a start pulse");
	a_cfg_no_data: assert property (i_cfg_valid |-> !i_data_valid)
		else $error("sample word during config frame");
	// Octet contents are checked before polarity, as sent
	a_adj_count_zero: assert property (i_cfg_start |-> ##2 i_lane_data[7:4] == 4'h0)
		else $error("adjust resolution not zero");
	a_adj_flags_zero: assert property (i_cfg_start |-> ##3 i_lane_data[7:5] == 3'h0)
		else $error("adjust flags or reserved bit not zero");
	a_scr_rsvd_zero: assert property (i_cfg_start |-> ##4 i_lane_data[6:5] == 2'h0)
		else $error("reserved bits of lane count octet set");
	a_octet_code: assert property (i_cfg_start |-> ##5 i_lane_data[7:0] inside {8'h00, 8'h01, 8'h03})
		else $error("octets per frame code not 0, 1 or 3");
endmodule

//--- jesd_rx_check_and_link_params_tb_top.sv
// Bench joining both ends over the link; APB tasks drive the receiver.
// Assumes zero or more wait states; waits are bounded by a counter.
`timescale 1ns/1ns
module jesd_rx_check_and_link_params_tb_top;
	import jrx_pkg::*;
	localparam int W = NUM_LANES * LANE_WIDTH;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [13:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, irq, setup_ok, rx_valid, busy, err;
	logic [W-1:0] rx_word, sword = '0;
	logic cfg_send = 1'b0, scr = 1'b0, svalid = 1'b0;
	logic [7:0] dev = '0, pol = '0;
	logic [3:0] bank = '0;
	logic [4:0] lid = '0, lcode = '0;
	logic [1:0] osel = '0;
	logic [4:0] lc [3] = '{5'h00, 5'h01, 5'h03};
	logic [11:0] rlist [10] = '{IDX_EXP_LOW, IDX_EXP_HIGH, IDX_CHECK_RESULT, IDX_LINK_SETUP,
		IDX_LANE_POLARITY, IDX_RX_DEVICE, IDX_RX_BANK, IDX_RX_LANE_ID, IDX_RX_SCR_L, IDX_RX_OCTETS};
	int errors = 0, checks_done = 0, cycles = 0;
	always #25 clk = ~clk;
	jrx_link_if link ();
	jrx_rx_regs u_jrx_rx_regs (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .link(link.rx),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq),
		.o_link_setup_ok(setup_ok), .o_rx_word(rx_word), .o_rx_valid(rx_valid));
	jrx_tx_end u_jrx_tx_end (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .link(link.tx),
		.i_cfg_send(cfg_send), .i_device_number(dev), .i_bank_number(bank),
		.i_lane_identifier(lid), .i_scramble(scr), .i_lane_count_code(lcode),
		.i_octets_sel(osel), .i_sample_word(sword), .i_sample_valid(svalid), .o_cfg_busy(busy));
	jrx_checker u_jrx_checker (.i_clk_sys(clk), .i_reset_n(rst_n), .i_lane_data(link.lane_data),
		.i_data_valid(link.data_valid), .i_cfg_start(link.cfg_start), .i_cfg_valid(link.cfg_valid));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task give_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high, then released an edge apart
	task apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task rdchk(input logic [11:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h00_0000, exp});
	endtask
	function logic [W-1:0] mk(input int k, input logic [15:0] v, input logic [15:0] f);
		logic [W-1:0] w;
		w = {(W/16){f}};
		w[k*16 +: 16] = v;
		return w;
	endfunction
	// Sample 9 (converter 2, index 1) sits in lane 4
	task send(input logic [W-1:0] w);
		sword <= w;
		svalid <= 1'b1;
		@(posedge clk);
		svalid <= 1'b0;
		while (rx_valid !== 1'b1) begin
			@(posedge clk);
		end
		chk(rx_word[159:128], w[159:128] ^ {32{pol[4]}});
		repeat (2) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'(setup_ok), 32'h0000_0000);
		foreach (rlist[j]) rdchk(rlist[j], 8'h00);
		apb(1'b1, IDX_LINK_SETUP, LINK_SETUP_VALUE);
		rdchk(IDX_LINK_SETUP, 8'h01);
		chk(32'(setup_ok), 32'h0000_0001);
		apb(1'b0, 12'h0100, 8'h00);
		chk({rd[30:0], err}, 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			dev <= 8'hA5 ^ 8'(i);
			bank <= 4'h9 - 4'(i);
			lid <= 5'h15 + 5'(i);
			scr <= i[0];
			lcode <= lc[i];
			osel <= 2'(i);
			cfg_send <= 1'b1;
			@(posedge clk);
			cfg_send <= 1'b0;
			repeat (2) @(posedge clk);
			chk(32'(busy), 32'h0000_0001);
			while (busy !== 1'b0) @(posedge clk);
			rdchk(IDX_RX_DEVICE, 8'hA5 ^ 8'(i));
			rdchk(IDX_RX_BANK, {4'h0, 4'h9 - 4'(i)});
			rdchk(IDX_RX_LANE_ID, {3'h0, 5'h15 + 5'(i)});
			rdchk(IDX_RX_SCR_L, {i[0], 2'h0, lc[i]});
			rdchk(IDX_RX_OCTETS, {3'h0, lc[i]});
			rdchk(IDX_IRQ_STATUS, 8'h02);
			apb(1'b1, IDX_IRQ_STATUS, 8'h02);
		end
		apb(1'b1, IDX_RX_DEVICE, 8'hFF);
		rdchk(IDX_RX_DEVICE, 8'hA7);
		apb(1'b1, IDX_EXP_LOW, 8'h34);
		apb(1'b1, IDX_EXP_HIGH, 8'h12);
		rdchk(IDX_EXP_LOW, 8'h34);
		rdchk(IDX_EXP_HIGH, 8'h12);
		apb(1'b1, IDX_CHECK_CTRL, 8'h19);
		apb(1'b1, IDX_IRQ_MASK, 8'h01);
		send(mk(9, 16'h1234, 16'h0000));
		rdchk(IDX_CHECK_RESULT, 8'h00);
		send(mk(8, 16'h1234, 16'h0000));
		rdchk(IDX_CHECK_RESULT, 8'h01);
		chk(32'(irq), 32'h0000_0001);
		apb(1'b1, IDX_IRQ_MASK, 8'h00);
		chk(32'(irq), 32'h0000_0000);
		apb(1'b1, IDX_IRQ_STATUS, 8'h01);
		rdchk(IDX_IRQ_STATUS, 8'h00);
		apb(1'b1, IDX_CHECK_CTRL, 8'h1B);
		apb(1'b1, IDX_CHECK_CTRL, 8'h18);
		rdchk(IDX_CHECK_RESULT, 8'h00);
		send(mk(9, 16'hFFFF, 16'h0000));
		rdchk(IDX_CHECK_RESULT, 8'h00);
		apb(1'b1, IDX_CHECK_CTRL, 8'h19);
		apb(1'b1, IDX_LANE_POLARITY, 8'h10);
		pol <= 8'h10;
		send(mk(9, 16'hEDCB, 16'hFFFF));
		rdchk(IDX_CHECK_RESULT, 8'h00);
		rdchk(IDX_LANE_POLARITY, 8'h10);
		give_verdict();
	end
endmodule
